// file: can_acceptance_filter_consts.svh
// Purpose: Offsets, field positions, reset values and steps of the
//          acceptance filter block.
// Assumes: Byte-wide registers on an 8-bit address port.
// Notes:   Definitions only.
`ifndef CAN_ACCEPTANCE_FILTER_CONSTS_SVH
`define CAN_ACCEPTANCE_FILTER_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CAF_OFS_CTRL 8'h00
`define CAF_OFS_ACK 8'h01
`define CAF_OFS_INT_STAT 8'h04
`define CAF_OFS_INT_MASK 8'h05
`define CAF_OFS_FG_ID0 8'h06
`define CAF_OFS_FG_ID1 8'h07
`define CAF_OFS_FG_ID2 8'h08
`define CAF_OFS_FG_ID3 8'h09
`define CAF_OFS_ACC_CTRL 8'h0B
`define CAF_OFS_RX_ERR 8'h0E
`define CAF_OFS_TX_ERR 8'h0F
`define CAF_FILT_PAGE 4'h1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CAF_BIT_INIT 0
`define CAF_BIT_SLEEP 1
`define CAF_BIT_RX 0
`define CAF_BIT_OVR 1
`define CAF_MODE_LSB 4
`define CAF_MODE_MSB 5
`define CAF_HIT_MSB 2
`define CAF_FILT_MASK_SEL 2
`define CAF_FILT_BANK_SEL 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CAF_RST_BYTE 8'h00
`define CAF_RST_INIT 1'b1
`define CAF_RST_SLEEP 1'b0
`define CAF_RST_FLAGS 2'h0
`define CAF_RST_HIT 3'h0

// ----------------------------------------
// Error counter steps
// ----------------------------------------
`define CAF_ERR_ZERO 8'h00
`define CAF_ERR_STEP_SMALL 8'h01
`define CAF_ERR_STEP_LARGE 8'h08
`define CAF_ERR_PASSIVE 8'h80
`define CAF_ERR_RX_RECOVER 8'h77
`define CAF_ERR_MAX 8'hFF

`endif

// file: caf_pkg.sv
// Purpose: Types of the acceptance filter block.
// Assumes: Used with can_acceptance_filter_consts.svh.
// Notes:   State of each module is one packed struct.
package caf_pkg;

  typedef enum logic [1:0] {
    CAF_MODE_32 = 2'b00,
    CAF_MODE_16 = 2'b01,
    CAF_MODE_8 = 2'b10,
    CAF_MODE_CLOSED = 2'b11
  } caf_mode_t;

  typedef enum logic [1:0] {
    CAF_RX_EMPTY = 2'b01,
    CAF_RX_PENDING = 2'b10
  } caf_rx_state_t;

  typedef struct packed {
    logic [7:0][7:0] code;
    logic [7:0][7:0] mask;
    caf_mode_t mode;
    logic init_req;
    logic init_ack;
    logic slp_req;
    logic slp_ack;
    caf_rx_state_t rx_st;
    logic [3:0][7:0] bg_id;
    logic bg_ext;
    logic [3:0][7:0] fg_id;
    logic [2:0] hit;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic [7:0] rdata;
  } caf_regs_t;

  typedef struct packed {
    logic [7:0] rec;
    logic [7:0] tec;
  } caf_cnt_t;

endpackage

// file: caf_error_counters.sv
// Purpose: Receive and transmit error counters.
// Assumes: Event inputs are one-cycle pulses from the bit engine.
// Notes:   Counters saturate at full scale; bus-off handling is outside.
`timescale 1ns/1ps
`default_nettype none
`include "can_acceptance_filter_consts.svh"

module caf_error_counters
  import caf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic cnt_clear,
  input wire logic rx_error,
  input wire logic rx_error_severe,
  input wire logic rx_ok,
  input wire logic tx_error,
  input wire logic tx_ok,
  output logic [7:0] receive_error_count,
  output logic [7:0] transmit_error_count
);

  caf_cnt_t q;
  caf_cnt_t next_q;

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[8] ? `CAF_ERR_MAX : s[7:0];
  endfunction

  // ----------------------------------------
  // Fault confinement counting
  // ----------------------------------------
  always_comb begin
    next_q = q;
    if (cnt_clear) begin
      next_q.rec = `CAF_ERR_ZERO;
      next_q.tec = `CAF_ERR_ZERO;
    end else begin
      if (rx_error_severe) begin
        next_q.rec = sat_add(q.rec, `CAF_ERR_STEP_LARGE);
      end else if (rx_error) begin
        next_q.rec = sat_add(q.rec, `CAF_ERR_STEP_SMALL);
      end else if (rx_ok) begin
        // Leaving error passive drops straight back into the active range
        if (q.rec >= `CAF_ERR_PASSIVE) begin
          next_q.rec = `CAF_ERR_RX_RECOVER;
        end else if (q.rec != `CAF_ERR_ZERO) begin
          next_q.rec = q.rec - `CAF_ERR_STEP_SMALL;
        end
      end
      if (tx_error) begin
        next_q.tec = sat_add(q.tec, `CAF_ERR_STEP_LARGE);
      end else if (tx_ok && q.tec != `CAF_ERR_ZERO) begin
        next_q.tec = q.tec - `CAF_ERR_STEP_SMALL;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q.rec <= `CAF_ERR_ZERO;
      q.tec <= `CAF_ERR_ZERO;
    end else begin
      q <= next_q;
    end
  end

  assign receive_error_count = q.rec;
  assign transmit_error_count = q.tec;

endmodule
`default_nettype wire

// file: can_acceptance_filter.sv
// Purpose: Receive identifier acceptance filter with its code, mask and
//          control registers, foreground buffer and error counter view.
// Assumes: sys_clk at 200 MHz; srst synchronous, active high; message
//          and error inputs synchronous one-cycle pulses.
// Notes:   Read data appear the cycle after the read strobe only.
`timescale 1ns/1ps
`default_nettype none
`include "can_acceptance_filter_consts.svh"

// How it works
// - Receive error count readable at 0x0E, read-only
// - Transmit error count readable at 0x0F, read-only
// - Every message outside init buffered; only accepted ones signalled
// - Compare each identifier byte bit by bit
// - In 32-bit mode extended uses four pairs, standard two
// - Code compared, then qualified by mask
// - Mask zero must match, one ignores
// - Code/mask writable only in acknowledged init
// - Mode field picks 32/16/8-bit or closed
// - Hit number updated on foreground load
module can_acceptance_filter
  import caf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic rx_msg_valid,
  input wire logic [3:0][7:0] received_identifier_bytes,
  input wire logic rx_extended,
  input wire logic rx_bit_error,
  input wire logic rx_error_severe,
  input wire logic rx_ok,
  input wire logic tx_error,
  input wire logic tx_ok,
  output logic irq,
  output logic init_acknowledge,
  output logic sleep_acknowledge,
  output logic [3:0][7:0] foreground_receive_buffer,
  output logic foreground_valid,
  output logic [2:0] filter_hit_number,
  output logic [7:0] receive_error_count,
  output logic [7:0] transmit_error_count
);

  caf_regs_t q;
  caf_regs_t next_q;

  logic in_init;
  logic filt_page;
  logic filt_wr;
  logic [2:0] filt_idx;
  logic [7:0] byte_ok;
  logic [7:0] filt_hit;
  logic filt_any;
  logic [2:0] hit_num;
  logic [7:0] acc_ctrl;

  // Writes to protected registers need both halves of the handshake
  assign in_init = q.init_req & q.init_ack;
  assign filt_page = (reg_addr[7:4] == `CAF_FILT_PAGE);
  assign filt_wr = reg_write & filt_page & in_init;
  assign filt_idx = {reg_addr[`CAF_FILT_BANK_SEL], reg_addr[1:0]};

  // ----------------------------------------
  // Per-register byte compare
  // ----------------------------------------
  // Each code/mask pair is held against one received byte; which byte
  // depends on the filter organisation.
  for (genvar k = 0; k < 8; k++) begin : g_cmp
    localparam logic [1:0] IDX32 = 2'(k % 4);
    localparam logic [1:0] IDX16 = 2'(k % 2);
    logic [1:0] id_sel;
    logic [7:0] bit_ok;
    always_comb begin
      case (q.mode)
        CAF_MODE_32: id_sel = IDX32;
        CAF_MODE_16: id_sel = IDX16;
        default: id_sel = 2'h0;
      endcase
    end
    // Equal bits, or bits the mask ignores, pass
    assign bit_ok = q.mask[k] | ~(q.code[k] ^ q.bg_id[id_sel]);
    assign byte_ok[k] = &bit_ok;
  end

  // ----------------------------------------
  // Filter organisation and hit priority
  // ----------------------------------------
  always_comb begin
    filt_hit = 8'h00;
    case (q.mode)
      CAF_MODE_32: begin
        for (int f = 0; f < 2; f++) begin
          // Standard frames stop after the first two pairs
          filt_hit[f] = byte_ok[4 * f] & byte_ok[4 * f + 1]
                        & (~q.bg_ext | (byte_ok[4 * f + 2]
                        & byte_ok[4 * f + 3]));
        end
      end
      CAF_MODE_16: begin
        for (int f = 0; f < 4; f++) begin
          filt_hit[f] = byte_ok[2 * f] & byte_ok[2 * f + 1];
        end
      end
      CAF_MODE_8: begin
        filt_hit = byte_ok;
      end
      default: begin
        filt_hit = 8'h00;
      end
    endcase
  end

  always_comb begin
    hit_num = `CAF_RST_HIT;
    // Scan downward so the lowest set filter is the last one kept
    for (int f = 7; f >= 0; f--) begin
      if (filt_hit[f]) begin
        hit_num = 3'(f);
      end
    end
  end

  assign filt_any = |filt_hit;

  // ----------------------------------------
  // Acceptance control read view
  // ----------------------------------------
  always_comb begin
    acc_ctrl = `CAF_RST_BYTE;
    acc_ctrl[`CAF_MODE_MSB:`CAF_MODE_LSB] = q.mode;
    acc_ctrl[`CAF_HIT_MSB:0] = q.hit;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [1:0] set_flags;
    logic [1:0] clr_flags;
    set_flags = `CAF_RST_FLAGS;
    clr_flags = `CAF_RST_FLAGS;
    next_q = q;
    next_q.rdata = `CAF_RST_BYTE;

    // Mode changes are acknowledged one cycle after the request
    next_q.init_ack = q.init_req;
    next_q.slp_ack = q.slp_req;

    // Receive path: judge the buffered message one cycle after arrival
    case (q.rx_st)
      CAF_RX_EMPTY: begin
        next_q.rx_st = CAF_RX_EMPTY;
      end
      CAF_RX_PENDING: begin
        next_q.rx_st = CAF_RX_EMPTY;
        if (filt_any) begin
          if (!q.int_stat[`CAF_BIT_RX]) begin
            next_q.fg_id = q.bg_id;
            next_q.hit = hit_num;
            set_flags[`CAF_BIT_RX] = 1'b1;
          end else begin
            // Foreground still owned by software: message is lost
            set_flags[`CAF_BIT_OVR] = 1'b1;
          end
        end
      end
      default: begin
        next_q.rx_st = CAF_RX_EMPTY;
      end
    endcase

    // A new arrival outside init always overwrites the background copy
    if (rx_msg_valid && !in_init) begin
      next_q.bg_id = received_identifier_bytes;
      next_q.bg_ext = rx_extended;
      next_q.rx_st = CAF_RX_PENDING;
    end

    // Register writes
    if (reg_write) begin
      case (reg_addr)
        `CAF_OFS_CTRL: begin
          next_q.init_req = reg_wdata[`CAF_BIT_INIT];
          next_q.slp_req = reg_wdata[`CAF_BIT_SLEEP];
        end
        `CAF_OFS_INT_STAT: begin
          clr_flags = reg_wdata[1:0];
        end
        `CAF_OFS_INT_MASK: begin
          next_q.int_mask = reg_wdata[1:0];
        end
        `CAF_OFS_ACC_CTRL: begin
          if (in_init) begin
            next_q.mode = caf_mode_t'(reg_wdata[`CAF_MODE_MSB:`CAF_MODE_LSB]);
          end
        end
        default: begin
          // Error counts and foreground bytes ignore writes
          next_q.mode = next_q.mode;
        end
      endcase
    end

    if (filt_wr) begin
      if (reg_addr[`CAF_FILT_MASK_SEL]) begin
        next_q.mask[filt_idx] = reg_wdata;
      end else begin
        next_q.code[filt_idx] = reg_wdata;
      end
    end

    // A flag raised in the clearing cycle survives the clear
    next_q.int_stat = (q.int_stat & ~clr_flags) | set_flags;

    // Register reads, answered on the next edge
    if (reg_read) begin
      case (reg_addr)
        `CAF_OFS_CTRL: begin
          next_q.rdata[`CAF_BIT_INIT] = q.init_req;
          next_q.rdata[`CAF_BIT_SLEEP] = q.slp_req;
        end
        `CAF_OFS_ACK: begin
          next_q.rdata[`CAF_BIT_INIT] = q.init_ack;
          next_q.rdata[`CAF_BIT_SLEEP] = q.slp_ack;
        end
        `CAF_OFS_INT_STAT: begin
          next_q.rdata[1:0] = q.int_stat;
        end
        `CAF_OFS_INT_MASK: begin
          next_q.rdata[1:0] = q.int_mask;
        end
        `CAF_OFS_FG_ID0: begin
          next_q.rdata = q.fg_id[0];
        end
        `CAF_OFS_FG_ID1: begin
          next_q.rdata = q.fg_id[1];
        end
        `CAF_OFS_FG_ID2: begin
          next_q.rdata = q.fg_id[2];
        end
        `CAF_OFS_FG_ID3: begin
          next_q.rdata = q.fg_id[3];
        end
        `CAF_OFS_ACC_CTRL: begin
          next_q.rdata = acc_ctrl;
        end
        `CAF_OFS_RX_ERR: begin
          // Only trustworthy while sleeping or initialising
          next_q.rdata = receive_error_count;
        end
        `CAF_OFS_TX_ERR: begin
          next_q.rdata = transmit_error_count;
        end
        default: begin
          if (filt_page) begin
            // Code and mask stay readable in every mode
            if (reg_addr[`CAF_FILT_MASK_SEL]) begin
              next_q.rdata = q.mask[filt_idx];
            end else begin
              next_q.rdata = q.code[filt_idx];
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q.code <= {8{`CAF_RST_BYTE}};
      q.mask <= {8{`CAF_RST_BYTE}};
      q.mode <= CAF_MODE_32;
      q.init_req <= `CAF_RST_INIT;
      q.init_ack <= `CAF_RST_INIT;
      q.slp_req <= `CAF_RST_SLEEP;
      q.slp_ack <= `CAF_RST_SLEEP;
      q.rx_st <= CAF_RX_EMPTY;
      q.bg_id <= {4{`CAF_RST_BYTE}};
      q.bg_ext <= 1'b0;
      q.fg_id <= {4{`CAF_RST_BYTE}};
      q.hit <= `CAF_RST_HIT;
      q.int_stat <= `CAF_RST_FLAGS;
      q.int_mask <= `CAF_RST_FLAGS;
      q.rdata <= `CAF_RST_BYTE;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // Error counters
  // ----------------------------------------
  // Counters are cleared while initialising, as after a controller restart
  caf_error_counters u_err (
    .sys_clk(sys_clk),
    .srst(srst),
    .cnt_clear(in_init),
    .rx_error(rx_bit_error),
    .rx_error_severe(rx_error_severe),
    .rx_ok(rx_ok),
    .tx_error(tx_error),
    .tx_ok(tx_ok),
    .receive_error_count(receive_error_count),
    .transmit_error_count(transmit_error_count)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = q.rdata;
  assign irq = |(q.int_stat & q.int_mask);
  assign init_acknowledge = q.init_ack;
  assign sleep_acknowledge = q.slp_ack;
  assign foreground_receive_buffer = q.fg_id;
  assign foreground_valid = q.int_stat[`CAF_BIT_RX];
  assign filter_hit_number = q.hit;

endmodule
`default_nettype wire

// file: caf_sva.sv
// Purpose: Port-level checks of the acceptance filter.
// Assumes: Single clock domain, srst synchronous active high.
// Notes:   Sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "can_acceptance_filter_consts.svh"

module caf_sva (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_msg_valid,
  input wire logic [3:0][7:0] received_identifier_bytes,
  input wire logic rx_bit_error,
  input wire logic rx_error_severe,
  input wire logic rx_ok,
  input wire logic tx_error,
  input wire logic tx_ok,
  input wire logic init_acknowledge,
  input wire logic sleep_acknowledge,
  input wire logic [3:0][7:0] foreground_receive_buffer,
  input wire logic foreground_valid,
  input wire logic [2:0] filter_hit_number,
  input wire logic [7:0] receive_error_count,
  input wire logic [7:0] transmit_error_count
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_load;
    $rose(foreground_valid);
  endsequence
  sequence s_ctrl_wr;
    reg_write && reg_addr == `CAF_OFS_CTRL;
  endsequence

  chk_rec_read: assert property (
    reg_read && reg_addr == `CAF_OFS_RX_ERR |=> reg_rdata == $past(receive_error_count))
    else $error("receive count read mismatch");
  chk_tec_read: assert property (
    reg_read && reg_addr == `CAF_OFS_TX_ERR |=> reg_rdata == $past(transmit_error_count))
    else $error("transmit count read mismatch");
  chk_rec_no_wr: assert property (
    reg_write && reg_addr == `CAF_OFS_RX_ERR && !init_acknowledge
    && !(rx_bit_error || rx_error_severe || rx_ok) |=> $stable(receive_error_count))
    else $error("receive count changed by write");
  chk_ack_follow: assert property (
    s_ctrl_wr |=> ##1
    8'({sleep_acknowledge, init_acknowledge}) == ($past(reg_wdata, 2) & 8'h03))
    else $error("mode acknowledge wrong");
  chk_load_cause: assert property (
    s_load |-> $past(rx_msg_valid, 2))
    else $error("foreground loaded without arrival");
  chk_load_ids: assert property (
    s_load |-> foreground_receive_buffer == $past(received_identifier_bytes, 2))
    else $error("foreground bytes wrong");
  chk_fg_hold: assert property (
    foreground_valid && $past(foreground_valid) |->
    $stable(foreground_receive_buffer) && $stable(filter_hit_number))
    else $error("foreground or hit changed while full");
  chk_rec_severe: assert property (
    !init_acknowledge && rx_error_severe |=> receive_error_count ==
    (($past(receive_error_count) > 8'hF7) ? 8'hFF : $past(receive_error_count) + 8'h08))
    else $error("receive count severe step wrong");
  chk_tec_ok: assert property (
    !init_acknowledge && tx_ok && !tx_error |=> transmit_error_count ==
    (($past(transmit_error_count) == 8'h00) ? 8'h00 : $past(transmit_error_count) - 8'h01))
    else $error("transmit count decrement wrong");
endmodule

bind can_acceptance_filter caf_sva chk_u (.sys_clk, .srst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .rx_msg_valid, .received_identifier_bytes,
  .rx_bit_error, .rx_error_severe, .rx_ok, .tx_error, .tx_ok, .init_acknowledge,
  .sleep_acknowledge, .foreground_receive_buffer, .foreground_valid, .filter_hit_number,
  .receive_error_count, .transmit_error_count);
`default_nettype wire

// file: caf_bus_node.sv
// Purpose: Behavioural far-side node feeding frames and error events.
// Assumes: Driven by task calls from the testbench.
// Notes:   Identifier lines show inverted bytes between frames.
`timescale 1ns/1ps
`default_nettype none

module caf_bus_node (
  input wire logic sys_clk,
  output logic rx_msg_valid,
  output logic [3:0][7:0] received_identifier_bytes,
  output logic rx_extended,
  output logic [4:0] ev
);
  initial begin
    rx_msg_valid = 1'b0;
    received_identifier_bytes = '0;
    rx_extended = 1'b0;
    ev = 5'h00;
  end

  // Inverting after the frame keeps stale bytes from passing for fresh ones
  task automatic send(input logic [31:0] id, input logic ext);
    @(posedge sys_clk);
    rx_msg_valid <= 1'b1;
    received_identifier_bytes <= id;
    rx_extended <= ext;
    @(posedge sys_clk);
    rx_msg_valid <= 1'b0;
    received_identifier_bytes <= ~id;
    rx_extended <= ~ext;
  endtask

  // The index stays on the right-hand side so no automatic variable steers an NBA
  task automatic pulse(input int k);
    @(posedge sys_clk);
    ev <= 5'h01 << k;
    @(posedge sys_clk);
    ev <= 5'h00;
  endtask
endmodule
`default_nettype wire

// file: can_acceptance_filter_tb.sv
// Purpose: Register-level test of the acceptance filter.
// Assumes: Far-side node model drives frames and error events.
// Notes:   Expected hits come from a local reference of the filter.
`timescale 1ns/1ps
`default_nettype none
`include "can_acceptance_filter_consts.svh"

module can_acceptance_filter_tb;
  logic sys_clk, srst, reg_write, reg_read, rx_msg_valid, rx_extended, irq;
  logic init_acknowledge, sleep_acknowledge, foreground_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, receive_error_count, transmit_error_count;
  logic [3:0][7:0] received_identifier_bytes, foreground_receive_buffer;
  logic [2:0] filter_hit_number;
  logic [4:0] ev;
  int n_checks, miscompares;
  logic [7:0] cd [8] = '{8'h11, 8'h22, 8'h33, 8'h5A, 8'h44, 8'h5A, 8'h66, 8'h77};
  logic [7:0] mk [8] = '{8'h00, 8'h07, 8'h00, 8'h0F, 8'h00, 8'h07, 8'h00, 8'h0F};
  logic [32:0] msg [5] = '{{1'b1, 32'h5A332211}, {1'b1, 32'h77665A44},
    {1'b0, 32'h0FF0255A}, {1'b0, 32'hEEEE2511}, {1'b1, 32'hEEEE2511}};
  int evs [6] = '{1, 1, 0, 2, 3, 4};

  caf_bus_node node_u (.sys_clk, .rx_msg_valid, .received_identifier_bytes,
    .rx_extended, .ev);
  can_acceptance_filter dut_u (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .rx_msg_valid, .received_identifier_bytes, .rx_extended,
    .rx_bit_error(ev[0]), .rx_error_severe(ev[1]), .rx_ok(ev[2]), .tx_error(ev[3]),
    .tx_ok(ev[4]), .irq, .init_acknowledge, .sleep_acknowledge,
    .foreground_receive_buffer, .foreground_valid, .filter_hit_number,
    .receive_error_count, .transmit_error_count);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Bus and check tasks, reference model
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, exp);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(nm, reg_rdata, exp);
  endtask

  // Returns {accepted, filter}; scanning downwards leaves the lowest match
  function automatic logic [3:0] ref_hit(input logic [1:0] m, input logic [32:0] g);
    logic [3:0] r;
    int w;
    logic ok;
    r = 4'h0;
    w = 4 >> m;
    if (m == 2'b11) return r;
    for (int f = 8 / w - 1; f >= 0; f--) begin
      ok = 1'b1;
      for (int b = 0; b < w; b++)
        if ((g[32] || b < 2) && ((g[8*b +: 8] ^ cd[w*f+b]) & ~mk[w*f+b]) != 8'h00) ok = 1'b0;
      if (ok) r = {1'b1, 3'(f)};
    end
    return r;
  endfunction

  task automatic results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [3:0] e;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    srst = 1'b1;
    n_checks = 0;
    miscompares = 0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    rdc("code0 reset", 8'h10, 8'h00);
    rdc("unmapped", 8'h02, 8'h00);
    rdc("rec reset", `CAF_OFS_RX_ERR, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(8'h10 + 8'({k[2], 1'b0, k[1:0]}), cd[k]);
      wr(8'h14 + 8'({k[2], 1'b0, k[1:0]}), mk[k]);
    end
    rdc("mask5", 8'h1D, 8'h07);
    wr(`CAF_OFS_INT_MASK, 8'h01);
    for (int m = 3; m >= 0; m--) begin
      wr(`CAF_OFS_CTRL, 8'h01);
      wr(`CAF_OFS_ACC_CTRL, 8'(m << 4));
      wr(`CAF_OFS_CTRL, 8'h00);
      for (int i = 0; i < 5; i++) begin
        wr(`CAF_OFS_INT_STAT, 8'h01);
        e = ref_hit(2'(m), msg[i]);
        node_u.send(msg[i][31:0], msg[i][32]);
        repeat (2) @(posedge sys_clk);
        #1 chk("accepted", foreground_valid, e[3]);
        chk("irq", irq, e[3]);
        if (e[3]) begin
          chk("foreground", foreground_receive_buffer, msg[i][31:0]);
          chk("hit port", filter_hit_number, e[2:0]);
          rdc("hit", `CAF_OFS_ACC_CTRL, 8'(m << 4) | 8'(e[2:0]));
        end
      end
    end
    // A second accepted frame while the first is unread only flags overrun
    node_u.send(msg[3][31:0], msg[3][32]);
    node_u.send(msg[0][31:0], msg[0][32]);
    repeat (2) @(posedge sys_clk);
    rdc("status", `CAF_OFS_INT_STAT, 8'h03);
    rdc("fg byte1", `CAF_OFS_FG_ID1, 8'h25);
    // Masked event stays pending without raising the interrupt
    wr(`CAF_OFS_INT_MASK, 8'h00);
    #1 chk("irq masked", irq, 1'b0);
    chk("still full", foreground_valid, 1'b1);
    wr(8'h10, 8'hFF);
    rdc("code0 locked", 8'h10, 8'h11);
    for (int j = 0; j < 6; j++) node_u.pulse(evs[j]);
    wr(`CAF_OFS_RX_ERR, 8'h55);
    wr(`CAF_OFS_TX_ERR, 8'hAA);
    wr(`CAF_OFS_CTRL, 8'h02);
    repeat (2) @(posedge sys_clk);
    #1 chk("sleep ack", sleep_acknowledge, 1'b1);
    rdc("ack reg", `CAF_OFS_ACK, 8'h02);
    rdc("rec", `CAF_OFS_RX_ERR, 8'h10);
    rdc("tec", `CAF_OFS_TX_ERR, 8'h07);
    chk("tec port", transmit_error_count, 8'h07);
    results();
  end

  initial begin
    #100us;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
